// ### rtl/README_SKIP.v
`timescale 1ns/1ns

// ### rtl/ssc_consts.vh
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SSC_ADDR_SETTINGS   4'h0
`define SSC_ADDR_FLAGS      4'h4
`define SSC_ADDR_STATUS     4'h8

// ---------------------------------------------------------------
// safety settings fields
// ---------------------------------------------------------------
`define SSC_SETTINGS_RESET  16'h0001
`define SSC_SET_BIST        0
`define SSC_SET_DIS_LSB     1
`define SSC_SET_MASK_LSB    6

// ---------------------------------------------------------------
// fault flag positions
// ---------------------------------------------------------------
`define SSC_FLAGS_RESET     13'h0000
`define SSC_FLG_TEST_LSB    0
`define SSC_FLG_CTRL        5
`define SSC_FLG_COMPL       6
`define SSC_FLG_PARITY      7
`define SSC_FLG_ADC         8
`define SSC_FLG_ADDER       9
`define SSC_FLG_ROT         10
`define SSC_FLG_ANG         11
`define SSC_FLG_TSENS       12

// ---------------------------------------------------------------
// timing and limits
// ---------------------------------------------------------------
`define SSC_CLK_PERIOD_NS   50
`define SSC_SLOT_TIME_NS    10000
`define SSC_DETECT_TIME_US  160
`define SSC_ADC_LIMIT_PCT   95

// ---------------------------------------------------------------
// calibration modes
// ---------------------------------------------------------------
`define SSC_CAL_MODE_7      2'h1
`define SSC_CAL_MODE_17     2'h2

`endif

// ### rtl/ssc_monitor.v
// Operation
// [R01] user tests run only while the global self-test enable bit is set
// [R02] each user test has its own disable bit
// [R03] field test flags temperature mismatch between sensor and amplitude estimate
// [R04] temperature sensor failure forces diagnostic mode
// [R05] inverted angle test: angle sum must equal clamp level sum
// [R06] inverted angle test failure forces diagnostic mode
// [R07] division test checks a known division result; mismatch forces diagnostic
// [R08] rotation test: main plus inverted rotation angle must be zero
// [R09] adjusted angle test compares against redundant zero-corrected value
// [R10] fixed monitors always run; each flag has its own mask bit
// [R11] control monitor flags incorrect main datapath processing
// [R12] completion monitor flags a selected test failure within 160 us
// [R13] sequencer state carries parity; mismatch is flagged
// [R14] sequencer slot number selects which test runs
// [R15] adc monitor flags filtered result above 95 percent full scale
// [R16] pre-rotation adder overflow sets a flag
// [R17] rotation arithmetic overflow is detected and flagged
// [R18] angular monitor flags clamp position seen before range position
// [R19] divider serves main path only in seventeen-point mode
// [R20] zero-corrected angle feeds output and segment detection
// [R21] sequencer is a 4-bit up-counter defining slots
// [R22] test ready clears its start; missing ready forces diagnostic (code sets the completion flag, so only while its mask bit is clear)
// [R23] masked fixed flag does not force diagnostic; unmasked does
// [R24] flags and sequencer clear on reset and stay set until it
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "ssc_consts.vh"

module ssc_monitor
#(
	parameter integer  ADC_W   = 16,
	parameter integer  ROT_W   = 18,
	parameter integer  TEMP_W  = 12,
	parameter [11:0]   TEMP_TOL = 12'h010,
	parameter [15:0]   DIV_NUM = 16'h4000,
	parameter [15:0]   DIV_DEN = 16'h0002,
	parameter [15:0]   DIV_EXP = 16'h2000
)
(
	input  wire              clk_i,
	input  wire              reset_n_i,
	input  wire              ce_i,
	input  wire [3:0]        addr_i,
	input  wire [15:0]       wr_data_i,
	input  wire              wr_stb_i,
	input  wire              rd_stb_i,
	output reg  [15:0]       rd_data_o,
	input  wire [4:0]        test_ready_i,
	input  wire [TEMP_W-1:0] temp_sensor_i,
	input  wire [TEMP_W-1:0] temp_amp_i,
	input  wire              temp_sensor_fail_i,
	input  wire [15:0]       angle_main_i,
	input  wire [15:0]       angle_inv_i,
	input  wire [15:0]       clamp_lo_i,
	input  wire [15:0]       clamp_hi_i,
	input  wire [15:0]       div_result_i,
	input  wire [15:0]       rot_angle_i,
	input  wire [15:0]       rot_inv_angle_i,
	input  wire [15:0]       adj_angle_i,
	input  wire [15:0]       adj_redundant_i,
	input  wire              proc_done_i,
	input  wire              proc_ok_i,
	input  wire [ADC_W-1:0]  adc_filt_i,
	input  wire              adc_valid_i,
	input  wire [15:0]       pre_add_a_i,
	input  wire [15:0]       pre_add_b_i,
	input  wire              pre_add_valid_i,
	input  wire [ROT_W-1:0]  rot_add_a_i,
	input  wire [ROT_W-1:0]  rot_add_b_i,
	input  wire              rot_add_valid_i,
	input  wire              sweep_start_i,
	input  wire              range_hit_i,
	input  wire              clamp_hit_i,
	input  wire [1:0]        cal_mode_i,
	output reg  [4:0]        test_start_o,
	output reg  [3:0]        test_slot_o,
	output reg  [15:0]       div_num_o,
	output reg  [15:0]       div_den_o,
	output reg               div_main_en_o,
	output reg  [15:0]       angle_out_o,
	output reg  [15:0]       seg_angle_o,
	output reg               seg_valid_o,
	output reg  [12:0]       safety_fault_flags_o,
	output reg               diag_mode_o
);

	localparam integer SLOT_CYC = (`SSC_SLOT_TIME_NS + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS;
	localparam integer ADC_LIM_INT = ((1 << (ADC_W - 1)) * `SSC_ADC_LIMIT_PCT) / 100;
	localparam [ADC_W:0] ADC_LIM = ADC_LIM_INT[ADC_W:0];

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function signed_ovf;
		input sa;
		input sb;
		input ss;
		begin
			signed_ovf = (sa == sb) && (ss != sa);
		end
	endfunction

	function [ADC_W:0] mag;
		input [ADC_W-1:0] v;
		begin
			if (v[ADC_W-1])
				mag = {1'b0, ~v} + {{ADC_W{1'b0}}, 1'b1};
			else
				mag = {1'b0, v};
		end
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	reg [15:0] safety_settings_reg;
	reg [12:0] flags_reg;
	reg [4:0]  start_reg;
	reg        cycle_fail_reg;
	reg        range_seen_reg;

	wire [3:0] seq_count;
	wire       seq_parity;
	wire       seq_tick;
	wire       seq_parity_err;

	ssc_seq
	#(
		.SLOT_CYC (SLOT_CYC),
		.PRE_W    (8)
	)
	u_seq
	(
		.clk_i        (clk_i),
		.reset_n_i    (reset_n_i),
		.ce_i         (ce_i),
		.count_o      (seq_count),
		.parity_o     (seq_parity),
		.slot_tick_o  (seq_tick),
		.parity_err_o (seq_parity_err)
	);

	// ---------------------------------------------------------------
	// test enables and masks
	// ---------------------------------------------------------------
	wire       bist_en = safety_settings_reg[`SSC_SET_BIST];                              // [R01]
	wire [4:0] test_en = {5{bist_en}} & ~safety_settings_reg[`SSC_SET_DIS_LSB +: 5];     // [R02]
	wire [6:0] fix_mask = safety_settings_reg[`SSC_SET_MASK_LSB +: 7];                  // [R10]

	// ---------------------------------------------------------------
	// test comparisons
	// ---------------------------------------------------------------
	wire [TEMP_W-1:0] temp_diff = (temp_sensor_i > temp_amp_i) ?
		(temp_sensor_i - temp_amp_i) : (temp_amp_i - temp_sensor_i);
	wire [16:0] ang_sum   = {1'b0, angle_main_i} + {1'b0, angle_inv_i};
	wire [16:0] clamp_sum = {1'b0, clamp_lo_i} + {1'b0, clamp_hi_i};
	wire [15:0] rot_sum   = rot_angle_i + rot_inv_angle_i;

	wire [4:0] test_bad;
	assign test_bad[0] = temp_diff > TEMP_TOL[TEMP_W-1:0];                    // [R03]
	assign test_bad[1] = ang_sum != clamp_sum;                                // [R05]
	assign test_bad[2] = div_result_i != DIV_EXP;                             // [R07]
	assign test_bad[3] = rot_sum != 16'h0000;                                 // [R08]
	assign test_bad[4] = adj_angle_i != adj_redundant_i;                      // [R09]

	wire [4:0] test_done = start_reg & test_ready_i;
	wire [4:0] test_fail = test_done & test_bad;
	wire [4:0] test_tmo  = start_reg & ~test_ready_i & {5{seq_tick}};

	// ---------------------------------------------------------------
	// fixed monitors
	// ---------------------------------------------------------------
	wire [15:0]      pre_sum = pre_add_a_i + pre_add_b_i;
	wire [ROT_W-1:0] rot_add_sum = rot_add_a_i + rot_add_b_i;

	wire ctrl_bad   = proc_done_i & ~proc_ok_i;                                              // [R11]
	wire adc_bad    = adc_valid_i & (mag(adc_filt_i) > ADC_LIM);                             // [R15]
	wire adder_bad  = pre_add_valid_i & signed_ovf(pre_add_a_i[15], pre_add_b_i[15], pre_sum[15]); // [R16]
	wire rot_bad    = rot_add_valid_i &
		signed_ovf(rot_add_a_i[ROT_W-1], rot_add_b_i[ROT_W-1], rot_add_sum[ROT_W-1]);           // [R17]
	wire ang_bad    = clamp_hit_i & ~range_seen_reg & ~range_hit_i;                          // [R18]
	wire cycle_end  = seq_tick & (seq_count == 4'h0);
	wire compl_bad  = cycle_end & (cycle_fail_reg | (|test_fail) | (|test_tmo));             // [R12]

	wire [12:0] flag_set;
	assign flag_set[4:0]              = test_fail;
	assign flag_set[`SSC_FLG_CTRL]    = ctrl_bad;
	assign flag_set[`SSC_FLG_COMPL]   = compl_bad;
	assign flag_set[`SSC_FLG_PARITY]  = seq_parity_err;                                      // [R13]
	assign flag_set[`SSC_FLG_ADC]     = adc_bad;
	assign flag_set[`SSC_FLG_ADDER]   = adder_bad;
	assign flag_set[`SSC_FLG_ROT]     = rot_bad;
	assign flag_set[`SSC_FLG_ANG]     = ang_bad;
	assign flag_set[`SSC_FLG_TSENS]   = temp_sensor_fail_i;                                  // [R04]

	// flags that may force diagnostic mode
	wire [12:0] flag_live = flags_reg & {1'b1, ~fix_mask, 5'h1f};                             // [R23]

	// ---------------------------------------------------------------
	// sequencing, flags and datapath routing
	// ---------------------------------------------------------------
	integer k;

	always @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			start_reg            <= 5'h00;
			flags_reg            <= `SSC_FLAGS_RESET;                                    // [R24]
			cycle_fail_reg       <= 1'b0;
			range_seen_reg       <= 1'b0;
			test_start_o         <= 5'h00;
			test_slot_o          <= 4'h0;
			div_num_o            <= 16'h0000;
			div_den_o            <= 16'h0000;
			div_main_en_o        <= 1'b0;
			angle_out_o          <= 16'h0000;
			seg_angle_o          <= 16'h0000;
			seg_valid_o          <= 1'b0;
			safety_fault_flags_o <= `SSC_FLAGS_RESET;
			diag_mode_o          <= 1'b0;
		end
		else if (ce_i)
		begin
			for (k = 0; k < 5; k = k + 1)
			begin
				if (test_done[k] || test_tmo[k])
					start_reg[k] <= 1'b0;                                            // [R22]
				else if (seq_tick && seq_count == k[3:0] && test_en[k])
					start_reg[k] <= 1'b1;                                            // [R14]
			end

			flags_reg <= flags_reg | flag_set;                                       // [R24]
			flags_reg[`SSC_FLG_COMPL] <= flags_reg[`SSC_FLG_COMPL] | compl_bad |
				(|test_tmo);                                                         // [R22]

			if (cycle_end)
				cycle_fail_reg <= 1'b0;
			else if ((|test_fail) || (|test_tmo))
				cycle_fail_reg <= 1'b1;

			if (range_hit_i)
				range_seen_reg <= 1'b1;
			else if (sweep_start_i)
				range_seen_reg <= 1'b0;

			test_start_o  <= start_reg;
			test_slot_o   <= seq_count;
			div_num_o     <= start_reg[2] ? DIV_NUM : 16'h0000;                          // [R07]
			div_den_o     <= start_reg[2] ? DIV_DEN : 16'h0000;
			div_main_en_o <= (cal_mode_i == `SSC_CAL_MODE_17) & ~start_reg[2];            // [R19]
			angle_out_o   <= adj_angle_i;                                                // [R20]
			seg_angle_o   <= adj_angle_i;
			seg_valid_o   <= (cal_mode_i == `SSC_CAL_MODE_7) | (cal_mode_i == `SSC_CAL_MODE_17);

			safety_fault_flags_o <= flags_reg;
			diag_mode_o          <= |flag_live;                                          // [R06]
		end
	end

	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	always @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			safety_settings_reg <= `SSC_SETTINGS_RESET;
			rd_data_o           <= 16'h0000;
		end
		else if (ce_i)
		begin
			if (wr_stb_i && addr_i == `SSC_ADDR_SETTINGS)
				safety_settings_reg <= wr_data_i;
			rd_data_o <= 16'h0000;
			if (rd_stb_i)
			begin
				case (addr_i)
					`SSC_ADDR_SETTINGS: rd_data_o <= safety_settings_reg;
					`SSC_ADDR_FLAGS:    rd_data_o <= {3'h0, flags_reg};
					`SSC_ADDR_STATUS:   rd_data_o <= {5'h00, seq_parity, seq_count, diag_mode_o, start_reg};
					default:            rd_data_o <= 16'h0000;
				endcase
			end
		end
	end

endmodule // ssc_monitor

`default_nettype wire

// ### rtl/ssc_seq.v
`timescale 1ns/1ns
`default_nettype none

module ssc_seq
#(
	parameter integer SLOT_CYC = 200,
	parameter integer PRE_W    = 8
)
(
	input  wire       clk_i,
	input  wire       reset_n_i,
	input  wire       ce_i,
	output reg  [3:0] count_o,
	output reg        parity_o,
	output reg        slot_tick_o,
	output reg        parity_err_o
);

	localparam integer     PRE_MAX_INT = SLOT_CYC - 1;
	localparam [PRE_W-1:0] PRE_MAX     = PRE_MAX_INT[PRE_W-1:0];

	reg [PRE_W-1:0] pre_reg;

	// ---------------------------------------------------------------
	// slot counter with even parity
	// ---------------------------------------------------------------
	always @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			pre_reg      <= {PRE_W{1'b0}};
			count_o      <= 4'h0;
			parity_o     <= 1'b0;
			slot_tick_o  <= 1'b0;
			parity_err_o <= 1'b0;
		end
		else if (ce_i)
		begin
			parity_err_o <= ^{parity_o, count_o};          // [R13]
			if (pre_reg == PRE_MAX)
			begin
				pre_reg     <= {PRE_W{1'b0}};
				count_o     <= count_o + 4'h1;             // [R21]
				parity_o    <= ^(count_o + 4'h1);
				slot_tick_o <= 1'b1;
			end
			else
			begin
				pre_reg     <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
				slot_tick_o <= 1'b0;
			end
		end
	end

endmodule // ssc_seq

`default_nettype wire

// ### tb/ssc_monitor_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ssc_props
#(
	parameter integer ADC_W = 16
)
(
	input wire logic             clk_i,
	input wire logic             reset_n_i,
	input wire logic             temp_sensor_fail_i,
	input wire logic             proc_done_i,
	input wire logic             proc_ok_i,
	input wire logic [ADC_W-1:0] adc_filt_i,
	input wire logic             adc_valid_i,
	input wire logic [1:0]       cal_mode_i,
	input wire logic [15:0]      adj_angle_i,
	input wire logic [4:0]       test_start_o,
	input wire logic [3:0]       test_slot_o,
	input wire logic [15:0]      div_num_o,
	input wire logic             div_main_en_o,
	input wire logic [15:0]      angle_out_o,
	input wire logic [12:0]      safety_fault_flags_o,
	input wire logic             diag_mode_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [7:0] gap_reg;
	logic [3:0] slot_prev_reg;
	logic [4:0] start_prev_reg;
	wire  [4:0] new_start = test_start_o & ~start_prev_reg;
	// cycles since the slot number last moved
	always_ff @(posedge clk_i)
	begin
		slot_prev_reg  <= test_slot_o;
		start_prev_reg <= test_start_o;
		gap_reg        <= (!reset_n_i || test_slot_o != slot_prev_reg) ? 8'h00 : gap_reg + 8'h01;
	end
	sticky_flags_a: assert property (($past(safety_fault_flags_o) & ~safety_fault_flags_o) == 13'h0000)
		else $error("fault flag cleared without reset");
	reset_clear_a: assert property (disable iff (1'b0) !reset_n_i |=> safety_fault_flags_o == 13'h0000
		&& !diag_mode_o && test_start_o == 5'h00) else $error("state not cleared by reset");
	unmaskable_diag_a: assert property (safety_fault_flags_o[4:0] != 5'h00 || safety_fault_flags_o[12]
		|-> ##[0:2] diag_mode_o) else $error("test failure without diagnostic mode");
	tsens_flag_a: assert property (temp_sensor_fail_i |-> ##[1:3] safety_fault_flags_o[12])
		else $error("sensor failure not flagged");
	ctrl_flag_a: assert property (proc_done_i && !proc_ok_i |-> ##[1:3] safety_fault_flags_o[5])
		else $error("bad processing not flagged");
	adc_flag_a: assert property (adc_valid_i && ($signed(adc_filt_i) > 31129 || $signed(adc_filt_i) < -31129)
		|-> ##[1:3] safety_fault_flags_o[8]) else $error("converter overrange not flagged");
	start_slot_a: assert property (new_start != 5'h00 |-> new_start == (5'h01 << test_slot_o))
		else $error("test started in wrong slot");
	slot_step_a: assert property (test_slot_o != $past(test_slot_o) |-> test_slot_o == $past(test_slot_o) + 4'h1)
		else $error("slot counter skipped");
	slot_gap_a: assert property (gap_reg <= 8'hc9)
		else $error("slot counter stalled");
	div_path_a: assert property ($past(reset_n_i) |-> div_num_o == (test_start_o[2] ? 16'h4000 : 16'h0000)
		&& div_main_en_o == ($past(cal_mode_i) == 2'h2 && !test_start_o[2])) else $error("divider routing wrong");
	angle_route_a: assert property ($past(reset_n_i) |-> angle_out_o == $past(adj_angle_i))
		else $error("angle output not routed");
endmodule // ssc_props

bind ssc_monitor ssc_props #(.ADC_W(ADC_W)) u_props
(
	.clk_i(clk_i), .reset_n_i(reset_n_i), .temp_sensor_fail_i(temp_sensor_fail_i), .proc_done_i(proc_done_i),
	.proc_ok_i(proc_ok_i), .adc_filt_i(adc_filt_i), .adc_valid_i(adc_valid_i), .cal_mode_i(cal_mode_i),
	.adj_angle_i(adj_angle_i), .test_start_o(test_start_o), .test_slot_o(test_slot_o), .div_num_o(div_num_o),
	.div_main_en_o(div_main_en_o), .angle_out_o(angle_out_o), .safety_fault_flags_o(safety_fault_flags_o),
	.diag_mode_o(diag_mode_o)
);
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        clk_i, reset_n_i, ce_i, wr_stb_i, rd_stb_i, temp_sensor_fail_i, proc_done_i, proc_ok_i, diag_mode_o;
	logic        adc_valid_i, pre_add_valid_i, rot_add_valid_i, sweep_start_i, range_hit_i, clamp_hit_i;
	logic [1:0]  cal_mode_i;
	logic [3:0]  addr_i;
	logic [4:0]  test_ready_i, test_start_o, resp_en, seen;
	logic [11:0] temp_sensor_i, temp_amp_i;
	logic [12:0] safety_fault_flags_o, exp_f;
	logic        seg_valid_o;
	logic [15:0] seg_angle_o, div_den_o;
	logic [17:0] exp_seg;
	logic [15:0] wr_data_i, rd_data_o, angle_main_i, angle_inv_i, clamp_lo_i, clamp_hi_i, div_result_i, s;
	logic [15:0] rot_angle_i, rot_inv_angle_i, adj_angle_i, adj_redundant_i, adc_filt_i, pre_add_a_i, pre_add_b_i;
	logic [17:0] rot_add_a_i, rot_add_b_i;
	logic [31:0] rnd, rb;
	int          bad_k, err_count = 0, checks = 0;

	ssc_monitor DUT
	(
		.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o), .test_ready_i(test_ready_i),
		.temp_sensor_i(temp_sensor_i), .temp_amp_i(temp_amp_i), .temp_sensor_fail_i(temp_sensor_fail_i),
		.angle_main_i(angle_main_i), .angle_inv_i(angle_inv_i), .clamp_lo_i(clamp_lo_i), .clamp_hi_i(clamp_hi_i),
		.div_result_i(div_result_i), .rot_angle_i(rot_angle_i), .rot_inv_angle_i(rot_inv_angle_i),
		.adj_angle_i(adj_angle_i), .adj_redundant_i(adj_redundant_i), .proc_done_i(proc_done_i),
		.proc_ok_i(proc_ok_i), .adc_filt_i(adc_filt_i), .adc_valid_i(adc_valid_i), .pre_add_a_i(pre_add_a_i),
		.pre_add_b_i(pre_add_b_i), .pre_add_valid_i(pre_add_valid_i), .rot_add_a_i(rot_add_a_i),
		.rot_add_b_i(rot_add_b_i), .rot_add_valid_i(rot_add_valid_i), .sweep_start_i(sweep_start_i),
		.range_hit_i(range_hit_i), .clamp_hit_i(clamp_hit_i), .cal_mode_i(cal_mode_i),
		.test_start_o(test_start_o), .test_slot_o(), .div_num_o(), .div_den_o(div_den_o), .div_main_en_o(),
		.angle_out_o(), .seg_angle_o(seg_angle_o), .seg_valid_o(seg_valid_o),
		.safety_fault_flags_o(safety_fault_flags_o),
		.diag_mode_o(diag_mode_o)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// datapath operands, consistent unless bad_k selects a test to break
	// ----------------------------------------
	always @(posedge clk_i)
	begin
		// outputs launched at the previous edge, against inputs seen there
		if (exp_seg[17] === 1'b1)
		begin
			chk(seg_angle_o, exp_seg[15:0]);
			chk({15'h0, seg_valid_o}, {15'h0, exp_seg[16]});
			chk(div_den_o, test_start_o[2] ? 16'h0002 : 16'h0000);
		end
		exp_seg = {reset_n_i, (cal_mode_i == 2'h1) || (cal_mode_i == 2'h2), adj_angle_i};
		rnd = $urandom;
		test_ready_i    <= test_start_o & resp_en & ~test_ready_i;
		seen            <= reset_n_i ? (seen | test_start_o) : 5'h00;
		cal_mode_i      <= rnd[1:0];
		temp_sensor_i   <= {1'b0, rnd[26:16]};
		temp_amp_i      <= {1'b0, rnd[26:16]} + ((bad_k == 0) ? 12'h100 : 12'h004);
		clamp_lo_i      <= {2'h0, rnd[13:0]};
		clamp_hi_i      <= 16'h4000 - {2'h0, rnd[13:0]};
		angle_main_i    <= {2'h0, rnd[29:16]};
		angle_inv_i     <= 16'h4000 - {2'h0, rnd[29:16]} + ((bad_k == 1) ? 16'h0001 : 16'h0000);
		div_result_i    <= (bad_k == 2) ? 16'h2001 : 16'h2000;
		rot_angle_i     <= rnd[31:16];
		rot_inv_angle_i <= 16'h0000 - rnd[31:16] + ((bad_k == 3) ? 16'h0001 : 16'h0000);
		adj_angle_i     <= rnd[15:0];
		adj_redundant_i <= rnd[15:0] + ((bad_k == 4) ? 16'h0001 : 16'h0000);
	end

	function automatic [12:0] exp_test(input int k, input logic [15:0] st);
		exp_test = (st[0] && !st[k + 1]) ? ((13'h0001 << k) | 13'h0040) : 13'h0000;
	endfunction

	function automatic logic add_ovf(input logic [15:0] a, input logic [15:0] b);
		add_ovf = (a[15] == b[15]) && ((a + b) >> 15 != {15'h0, a[15]});
	endfunction

	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task fchk(input logic [12:0] e, input logic d);
		cyc(4);
		#1;
		chk({2'h0, diag_mode_o, safety_fault_flags_o}, {2'h0, d, e});
	endtask

	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		{addr_i, wr_data_i, wr_stb_i} <= {a, d, 1'b1};
		@(posedge clk_i);
		wr_stb_i <= 1'b0;
	endtask

	task rdc(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_i);
		{addr_i, rd_stb_i} <= {a, 1'b1};
		@(posedge clk_i);
		rd_stb_i <= 1'b0;
		#1;
		chk(rd_data_o, e);
	endtask

	task rst(input logic [15:0] st);
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		cyc(3);
		reset_n_i <= 1'b1;
		wr(4'h0, st);
	endtask

	task end_of_test;
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'h89a2_67ba));
		{ce_i, bad_k, resp_en} = {1'b1, 32'd5, 5'h1f};
		{reset_n_i, wr_stb_i, rd_stb_i, temp_sensor_fail_i, proc_done_i, proc_ok_i, adc_valid_i} = '0;
		{pre_add_valid_i, rot_add_valid_i, sweep_start_i, range_hit_i, clamp_hit_i, test_ready_i} = '0;
		{addr_i, wr_data_i, adc_filt_i, pre_add_a_i, pre_add_b_i, rot_add_a_i, rot_add_b_i, cal_mode_i} = '0;
		{temp_sensor_i, temp_amp_i, clamp_lo_i, clamp_hi_i, angle_main_i, angle_inv_i, div_result_i} = '0;
		{rot_angle_i, rot_inv_angle_i, adj_angle_i, adj_redundant_i} = '0;
		cyc(20);
		reset_n_i <= 1'b1;
		rdc(4'h0, 16'h0001);
		wr(4'h4, 16'hffff);
		rdc(4'h4, 16'h0000);
		rdc(4'hc, 16'h0000);
		for (int k = 0; k < 6; k++)
		begin
			bad_k = k % 5;
			s = (k == 5) ? 16'h0000 : 16'h0001 | (16'h003e & ~(16'h0002 << k));
			rst(s);
			cyc(6500);
			fchk(exp_test(bad_k, s), s[0]);
			chk({11'h0, seen}, s[0] ? {11'h0, 5'h01 << k} : 16'h0000);
		end
		bad_k = 5;
		resp_en <= 5'h0f;
		rst(16'h0001);
		cyc(3400);
		fchk(13'h0040, 1'b1);
		resp_en <= 5'h1f;
		// fixed monitors, all masked, just inside the limits
		rst(16'h1fc1);
		@(posedge clk_i);
		{adc_valid_i, pre_add_valid_i, rot_add_valid_i, sweep_start_i} <= 4'hf;
		{adc_filt_i, pre_add_a_i, pre_add_b_i} <= {16'h7999, 16'h7ffe, 16'h0001};
		{rot_add_a_i, rot_add_b_i} <= {18'h1_fffe, 18'h0_0001};
		@(posedge clk_i);
		{adc_filt_i, sweep_start_i, range_hit_i} <= {16'h8667, 1'b0, 1'b1};
		@(posedge clk_i);
		{range_hit_i, clamp_hit_i} <= 2'h1;
		fchk(13'h0000, 1'b0);
		exp_f = 13'h0000;
		repeat (24)
		begin
			@(posedge clk_i);
			rb = $urandom;
			{pre_add_a_i, pre_add_b_i, clamp_hit_i} <= {rb, 1'b0};
			exp_f[9] = exp_f[9] | add_ovf(rb[31:16], rb[15:0]);
			fchk(exp_f, 1'b0);
		end
		@(posedge clk_i);
		{pre_add_valid_i, proc_done_i, proc_ok_i, sweep_start_i} <= 4'h5;
		{adc_filt_i, rot_add_a_i} <= {16'h799a, 18'h1_ffff};
		@(posedge clk_i);
		{adc_valid_i, rot_add_valid_i, proc_done_i, proc_ok_i, sweep_start_i, clamp_hit_i} <= 6'h05;
		exp_f = exp_f | 13'h0d20;
		fchk(exp_f, 1'b0);
		@(posedge clk_i);
		{clamp_hit_i, temp_sensor_fail_i} <= 2'h1;
		@(posedge clk_i);
		temp_sensor_fail_i <= 1'b0;
		fchk(exp_f | 13'h1000, 1'b1);
		rdc(4'h4, {3'h0, exp_f | 13'h1000});
		rst(16'h0001);
		@(posedge clk_i);
		{adc_valid_i, adc_filt_i} <= {1'b1, 16'h8666};
		@(posedge clk_i);
		adc_valid_i <= 1'b0;
		fchk(13'h0100, 1'b1);
		end_of_test;
	end

	initial
	begin
		#4_000_000;
		err_count++;
		end_of_test;
	end
endmodule // tb_top
`default_nettype wire
